// ==== hw/sfar_pkg.sv ====
`default_nettype none
package sfar_pkg;

   // ---------------------------------------------------------------
   // sizes
   // ---------------------------------------------------------------
   localparam int              ADDR_W     = 32;
   localparam int              WORD_W     = 16;  // one byte from each die
   localparam int              FIFO_DEPTH = 4;
   localparam int              PIN_W      = 10;  // cs, clock, eight io lines
   localparam int              A24_W      = 24;
   localparam int              BANK_W     = 7;
   localparam int              BANK_EXT   = 7;   // wide address enable bit
   localparam int              PIN_CS     = 9;
   localparam int              PIN_SCK    = 8;
   localparam logic [7:0]      BANK_RESET = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_LAST = 32'h01ff_ffff;

   // ---------------------------------------------------------------
   // opcodes and field values
   // ---------------------------------------------------------------
   localparam logic [7:0] OP_READ   = 8'h03;
   localparam logic [7:0] OP_READ_W = 8'h13;
   localparam logic [7:0] OP_FAST   = 8'h0b;
   localparam logic [7:0] OP_FAST_W = 8'h0c;
   localparam logic [7:0] OP_QOR    = 8'h6b;
   localparam logic [7:0] OP_QOR_W  = 8'h6c;
   localparam logic [7:0] OP_QIO    = 8'heb;
   localparam logic [7:0] OP_QIO_W  = 8'hec;
   localparam logic [7:0] OP_DQIO   = 8'hed;
   localparam logic [7:0] OP_DQIO_W = 8'hee;
   localparam logic [3:0] MODE_CONT_NIB = 4'ha;
   localparam logic [1:0] LC_NO_DUMMY   = 2'h3;

   // ---------------------------------------------------------------
   // edge counts
   // ---------------------------------------------------------------
   localparam logic [5:0] INSTR_LAST  = 6'h07;
   localparam logic [5:0] ADDR_SER_3  = 6'h17;
   localparam logic [5:0] ADDR_SER_4  = 6'h1f;
   localparam logic [5:0] ADDR_QUAD_3 = 6'h05;
   localparam logic [5:0] ADDR_QUAD_4 = 6'h07;
   localparam logic [5:0] DUMMY_NONE  = 6'h00;
   localparam logic [5:0] DUMMY_FAST  = 6'h08;
   localparam logic [5:0] DLP_CYCLES  = 6'h04;
   localparam logic [2:0] SER_LAST    = 3'h7;
   localparam logic [2:0] QUAD_LAST   = 3'h1;
   localparam logic [7:0] OE_SER      = 8'h22;
   localparam logic [7:0] OE_QUAD     = 8'hff;
   localparam logic [5:0] MIO_DUMMY [4] = '{6'h08, 6'h04, 6'h05, 6'h01};
   localparam logic [5:0] DDR_DUMMY [4] = '{6'h06, 6'h04, 6'h05, 6'h02};

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE   = 3'h0,
      ST_INSTR  = 3'h1,
      ST_ADDR   = 3'h3,
      ST_MODE   = 3'h2,
      ST_DUMMY  = 3'h6,
      ST_DATA   = 3'h7,
      ST_IGNORE = 3'h5
   } sfar_state_e;

   typedef enum logic [1:0] {
      KIND_READ = 2'h0,
      KIND_FAST = 2'h1,
      KIND_QOR  = 2'h2,
      KIND_QIO  = 2'h3
   } sfar_kind_e;

   typedef struct packed {
      logic       ok;
      logic       wide;
      logic       ddr;
      sfar_kind_e kind;
   } sfar_cmd_s;

   // opcode to command class, unknown codes come back not ok
   function automatic sfar_cmd_s sfar_decode(input logic [7:0] op);
      sfar_cmd_s c;
      c = '{ok: 1'b1, wide: 1'b0, ddr: 1'b0, kind: KIND_READ};
      case (op)
         OP_READ:   c.kind = KIND_READ;
         OP_READ_W: c.wide = 1'b1;
         OP_FAST:   c.kind = KIND_FAST;
         OP_FAST_W: c = '{ok: 1'b1, wide: 1'b1, ddr: 1'b0, kind: KIND_FAST};
         OP_QOR:    c.kind = KIND_QOR;
         OP_QOR_W:  c = '{ok: 1'b1, wide: 1'b1, ddr: 1'b0, kind: KIND_QOR};
         OP_QIO:    c.kind = KIND_QIO;
         OP_QIO_W:  c = '{ok: 1'b1, wide: 1'b1, ddr: 1'b0, kind: KIND_QIO};
         OP_DQIO:   c = '{ok: 1'b1, wide: 1'b0, ddr: 1'b1, kind: KIND_QIO};
         OP_DQIO_W: c = '{ok: 1'b1, wide: 1'b1, ddr: 1'b1, kind: KIND_QIO};
         default:   c.ok = 1'b0;
      endcase
      return c;
   endfunction

   // dummy cycles from command class and latency code
   function automatic logic [5:0] sfar_dummy(input sfar_cmd_s c, input logic [1:0] lc);
      logic [5:0] n;
      case (c.kind)
         KIND_READ: n = DUMMY_NONE;
         KIND_FAST: n = (lc == LC_NO_DUMMY) ? DUMMY_NONE : DUMMY_FAST;
         default:   n = c.ddr ? DDR_DUMMY[lc] : MIO_DUMMY[lc];
      endcase
      return n;
   endfunction

endpackage
`default_nettype wire

// ==== hw/sfar_top.sv ====
// What this block does
// - instruction arrives serially, one bit per rising serial clock edge.
// - 03h uses 3 or 4 address bytes per wide enable; 13h uses four.
// - plain and fast read return data on IO1 and IO5, one per die.
// - 0Bh uses 3 or 4 address bytes per wide enable; 0Ch uses four.
// - fast read waits zero or eight dummy cycles per latency code.
// - 6Bh uses 3 or 4 address bytes per wide enable; 6Ch uses four.
// - quad output drives a nibble per die on each falling edge.
// - address steps each byte and wraps to zero after the last.
// - 3-byte commands take high bits from bank register, reset zero.
// - bank register wide bit set forces 4-byte addresses on old opcodes.
// - quad I/O reads capture mode bits after the address.
// - anything presented during dummy cycles is ignored.
// - dummy count comes from latency code, counted fall to fall.
// - zero dummy means data starts on the fall ending address input.
// - double rate reads may drive an 8-edge learning pattern before data.
// - chip select high during data ends the read at once.
// - mode nibble A keeps continuous read; other values release at deselect.
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------------
// small word fifo between array fetch and serializer
// ------------------------------------------------------------------
module sfar_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   input  wire logic             clk_sys,
   input  wire logic             resetn,
   input  wire logic             flush,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [PW-1:0]    wrPtr_ff;
   logic [PW-1:0]    rdPtr_ff;
   logic [CW-1:0]    count_ff;
   wire              push = inValid & inReady;
   wire              pop  = outValid & outReady;

   // honest full and empty from the fill count
   assign inReady  = (count_ff != CW'(DEPTH));
   assign outValid = (count_ff != '0);
   assign outData  = mem_ff[rdPtr_ff];

   // storage, no reset needed on data
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem_ff[wrPtr_ff] <= inData;
      end
   end

   // pointers and count, flush wins over traffic
   always_ff @(posedge clk_sys) begin
      if (!resetn || flush) begin
         wrPtr_ff <= '0;
         rdPtr_ff <= '0;
         count_ff <= '0;
      end else begin
         if (push) begin
            wrPtr_ff <= (wrPtr_ff == PW'(DEPTH - 1)) ? '0 : wrPtr_ff + PW'(1);
         end
         if (pop) begin
            rdPtr_ff <= (rdPtr_ff == PW'(DEPTH - 1)) ? '0 : rdPtr_ff + PW'(1);
         end
         if (push && !pop) begin
            count_ff <= count_ff + CW'(1);
         end else if (pop && !push) begin
            count_ff <= count_ff - CW'(1);
         end
      end
   end
endmodule

// ------------------------------------------------------------------
// array read front end
// ------------------------------------------------------------------
module sfar_top (
   input  wire logic        clk_sys,
   input  wire logic        resetn,
   input  wire logic        sck,
   input  wire logic        csN,
   input  wire logic [7:0]  ioIn,
   output logic      [7:0]  ioOut,
   output logic      [7:0]  ioOe,
   input  wire logic [1:0]  latencyCode,
   input  wire logic        dlpEnable,
   input  wire logic [7:0]  dlpPattern,
   input  wire logic        bankLoad,
   input  wire logic [7:0]  bankData,
   output logic      [7:0]  bankValue,
   output logic             contMode,
   output logic             arrReq,
   output logic      [31:0] arrAddr,
   input  wire logic        arrValid,
   input  wire logic [15:0] arrData
);
   // ---------------------------------------------------------------
   // pin synchronisers and edge detection
   // ---------------------------------------------------------------
   logic [sfar_pkg::PIN_W-1:0] pinMeta_ff;
   logic [sfar_pkg::PIN_W-1:0] pinSync_ff;
   logic                       sckDly_ff;
   logic                       csDly_ff;

   // two flops on every pin; only the second stage is looked at
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         pinMeta_ff <= {1'b1, {(sfar_pkg::PIN_W - 1){1'b0}}};
         pinSync_ff <= {1'b1, {(sfar_pkg::PIN_W - 1){1'b0}}};
         sckDly_ff  <= 1'b0;
         csDly_ff   <= 1'b1;
      end else begin
         pinMeta_ff <= {csN, sck, ioIn};
         pinSync_ff <= pinMeta_ff;
         sckDly_ff  <= pinSync_ff[sfar_pkg::PIN_SCK];
         csDly_ff   <= pinSync_ff[sfar_pkg::PIN_CS];
      end
   end

   wire       sckS    = pinSync_ff[sfar_pkg::PIN_SCK];
   wire       csS     = pinSync_ff[sfar_pkg::PIN_CS];
   wire [7:0] ioS     = pinSync_ff[7:0];
   wire       sckRise = sckS & ~sckDly_ff;
   wire       sckFall = ~sckS & sckDly_ff;
   wire       csRise  = csS & ~csDly_ff;
   wire       csFall  = ~csS & csDly_ff;

   // ---------------------------------------------------------------
   // command state
   // ---------------------------------------------------------------
   sfar_pkg::sfar_state_e state_ff;
   sfar_pkg::sfar_state_e nxt_state;
   sfar_pkg::sfar_cmd_s   cmd_ff;
   sfar_pkg::sfar_cmd_s   nxt_cmd;
   logic [5:0]            cnt_ff;
   logic [5:0]            nxt_cnt;
   logic [31:0]           shift_ff;
   logic [31:0]           nxt_shift;
   logic                  modeHit_ff;
   logic                  nxt_modeHit;
   logic                  contMode_ff;
   logic                  nxt_contMode;
   logic                  addrDone;
   logic [7:0]            bank_ff;

   // per command decode of widths and edges
   wire        quadIn   = (cmd_ff.kind == sfar_pkg::KIND_QIO);
   wire        quadOut  = (cmd_ff.kind == sfar_pkg::KIND_QOR) | quadIn;
   wire        wide4    = cmd_ff.wide | bank_ff[sfar_pkg::BANK_EXT];
   wire        capEdge  = sckRise | (cmd_ff.ddr & sckFall);
   wire [31:0] serBits  = {shift_ff[30:0], ioS[0]};
   wire [31:0] quadBits = {shift_ff[27:0], ioS[3:0]};
   wire [31:0] addrBits = quadIn ? quadBits : serBits;
   wire [5:0]  addrLast = quadIn ? (wide4 ? sfar_pkg::ADDR_QUAD_4 : sfar_pkg::ADDR_QUAD_3)
                                 : (wide4 ? sfar_pkg::ADDR_SER_4 : sfar_pkg::ADDR_SER_3);
   // bank bits fill the top of short addresses
   wire [31:0] startAddr = wide4 ? addrBits
                         : {1'b0, bank_ff[sfar_pkg::BANK_W-1:0], addrBits[sfar_pkg::A24_W-1:0]};
   wire sfar_pkg::sfar_cmd_s decoded = sfar_pkg::sfar_decode(serBits[7:0]);
   wire [5:0]  dumTarget = sfar_pkg::sfar_dummy(cmd_ff, latencyCode);
   wire        dumDone   = (cnt_ff == dumTarget);

   // next state of the command sequencer
   always_comb begin
      nxt_state    = state_ff;
      nxt_cmd      = cmd_ff;
      nxt_cnt      = cnt_ff;
      nxt_shift    = shift_ff;
      nxt_modeHit  = modeHit_ff;
      nxt_contMode = contMode_ff;
      addrDone     = 1'b0;
      if (csRise) begin
         nxt_state    = sfar_pkg::ST_IDLE;
         // only a completed mode phase keeps continuous read
         nxt_contMode = ((state_ff == sfar_pkg::ST_DUMMY) || (state_ff == sfar_pkg::ST_DATA))
                        && quadIn && modeHit_ff;
      end else if (csFall) begin
         nxt_cnt   = '0;
         nxt_shift = '0;
         nxt_state = contMode_ff ? sfar_pkg::ST_ADDR : sfar_pkg::ST_INSTR;
      end else begin
         case (state_ff)
            sfar_pkg::ST_INSTR: begin
               if (sckRise) begin
                  nxt_shift = serBits;
                  nxt_cnt   = cnt_ff + 6'h01;
                  if (cnt_ff == sfar_pkg::INSTR_LAST) begin
                     nxt_cmd   = decoded;
                     nxt_cnt   = '0;
                     nxt_state = decoded.ok ? sfar_pkg::ST_ADDR : sfar_pkg::ST_IGNORE;
                  end
               end
            end
            sfar_pkg::ST_ADDR: begin
               if (capEdge) begin
                  nxt_shift = addrBits;
                  nxt_cnt   = cnt_ff + 6'h01;
                  if (cnt_ff == addrLast) begin
                     addrDone  = 1'b1;
                     nxt_cnt   = '0;
                     nxt_state = quadIn ? sfar_pkg::ST_MODE : sfar_pkg::ST_DUMMY;
                  end
               end
            end
            sfar_pkg::ST_MODE: begin
               if (capEdge) begin
                  nxt_cnt = cnt_ff + 6'h01;
                  if (cnt_ff == '0) begin
                     nxt_modeHit = (ioS[3:0] == sfar_pkg::MODE_CONT_NIB);
                  end else begin
                     nxt_cnt   = '0;
                     nxt_state = sfar_pkg::ST_DUMMY;
                  end
               end
            end
            sfar_pkg::ST_DUMMY: begin
               // inputs unread; zero target leaves on first fall
               if (sckFall) begin
                  if (dumDone) begin
                     nxt_state = sfar_pkg::ST_DATA;
                  end else begin
                     nxt_cnt = cnt_ff + 6'h01;
                  end
               end
            end
            sfar_pkg::ST_IDLE, sfar_pkg::ST_DATA, sfar_pkg::ST_IGNORE: begin
               nxt_state = state_ff;
            end
            default: nxt_state = sfar_pkg::ST_IDLE;
         endcase
      end
   end

   // sequencer registers
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         state_ff    <= sfar_pkg::ST_IDLE;
         cmd_ff      <= '0;
         cnt_ff      <= '0;
         shift_ff    <= '0;
         modeHit_ff  <= 1'b0;
         contMode_ff <= 1'b0;
      end else begin
         state_ff    <= nxt_state;
         cmd_ff      <= nxt_cmd;
         cnt_ff      <= nxt_cnt;
         shift_ff    <= nxt_shift;
         modeHit_ff  <= nxt_modeHit;
         contMode_ff <= nxt_contMode;
      end
   end

   // bank register, loadable and readable, resets to zero
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         bank_ff <= sfar_pkg::BANK_RESET;
      end else if (bankLoad) begin
         bank_ff <= bankData;
      end
   end

   // ---------------------------------------------------------------
   // array fetch into the fifo
   // ---------------------------------------------------------------
   logic        fetchOn_ff;
   logic        inflight_ff;
   logic        arrReq_ff;
   logic [31:0] arrAddr_ff;
   logic        fifoInReady;
   logic        fifoOutValid;
   logic [15:0] fifoOut;
   logic        fifoPop;

   // one request in flight; full fifo stalls the next one
   wire issue   = fetchOn_ff & ~inflight_ff & ~arrReq_ff & fifoInReady & ~csRise;
   wire arrTake = arrValid & inflight_ff;

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         fetchOn_ff  <= 1'b0;
         inflight_ff <= 1'b0;
         arrReq_ff   <= 1'b0;
         arrAddr_ff  <= '0;
      end else begin
         arrReq_ff <= issue;
         if (csRise) begin
            fetchOn_ff <= 1'b0;
         end else if (addrDone) begin
            fetchOn_ff <= 1'b1;
         end
         if (issue) begin
            inflight_ff <= 1'b1;
         end else if (arrValid) begin
            inflight_ff <= 1'b0;
         end
         // step per word, wrap after the top address
         if (addrDone) begin
            arrAddr_ff <= startAddr;
         end else if (arrTake) begin
            arrAddr_ff <= (arrAddr_ff == sfar_pkg::ADDR_LAST) ? '0 : arrAddr_ff + 32'h1;
         end
      end
   end

   // late answers after deselect are dropped, not queued
   sfar_fifo #(
      .WIDTH (sfar_pkg::WORD_W),
      .DEPTH (sfar_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk_sys  (clk_sys),
      .resetn   (resetn),
      .flush    (csRise),
      .inValid  (arrTake & fetchOn_ff),
      .inReady  (fifoInReady),
      .inData   (arrData),
      .outValid (fifoOutValid),
      .outReady (fifoPop),
      .outData  (fifoOut)
   );

   // ---------------------------------------------------------------
   // serializer and learning pattern
   // ---------------------------------------------------------------
   logic [2:0]  bitIdx_ff;
   logic [15:0] word_ff;
   logic [2:0]  dlpIdx_ff;
   logic [7:0]  ioOut_ff;
   logic [7:0]  ioOe_ff;
   logic [7:0]  nxt_ioOut;
   logic [7:0]  nxt_ioOe;

   wire        inData   = (state_ff == sfar_pkg::ST_DATA);
   wire        inDummy  = (state_ff == sfar_pkg::ST_DUMMY);
   wire        outGo    = ~csRise & ((inData & (sckFall | (cmd_ff.ddr & sckRise)))
                                   | (inDummy & sckFall & dumDone));
   wire [2:0]  lastIdx  = quadOut ? sfar_pkg::QUAD_LAST : sfar_pkg::SER_LAST;
   wire        wordNew  = (bitIdx_ff == '0);
   wire [15:0] curWord  = wordNew ? fifoOut : word_ff;
   wire [2:0]  serPos   = sfar_pkg::SER_LAST - bitIdx_ff;
   wire        hiNib    = ~bitIdx_ff[0];
   wire [3:0]  die0Nib  = hiNib ? curWord[7:4] : curWord[3:0];
   wire [3:0]  die1Nib  = hiNib ? curWord[15:12] : curWord[11:8];
   // pattern window covers the last four dummy cycles
   wire        dlpArm   = cmd_ff.ddr & dlpEnable & (dumTarget >= sfar_pkg::DLP_CYCLES)
                          & (cnt_ff >= dumTarget - sfar_pkg::DLP_CYCLES);
   wire        dlpFall  = inDummy & sckFall & ~dumDone & dlpArm;
   wire        dlpRise  = inDummy & sckRise & dlpIdx_ff[0];
   wire        dlpGo    = ~csRise & (dlpFall | dlpRise);
   wire        dlpBit   = dlpPattern[sfar_pkg::SER_LAST - dlpIdx_ff];

   assign fifoPop = outGo & wordNew & fifoOutValid;

   // output pin values and enables
   always_comb begin
      nxt_ioOut = ioOut_ff;
      nxt_ioOe  = ioOe_ff;
      if (csRise) begin
         nxt_ioOe = '0;
      end else if (dlpGo) begin
         nxt_ioOut = {8{dlpBit}};
         nxt_ioOe  = sfar_pkg::OE_QUAD;
      end else if (outGo && quadOut) begin
         // one nibble per die per edge
         nxt_ioOut = {die1Nib, die0Nib};
         nxt_ioOe  = sfar_pkg::OE_QUAD;
      end else if (outGo) begin
         // serial data on IO1 and IO5
         nxt_ioOut    = '0;
         nxt_ioOut[1] = curWord[serPos];
         nxt_ioOut[5] = curWord[{1'b1, serPos}];
         nxt_ioOe     = sfar_pkg::OE_SER;
      end
   end

   // serializer registers
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         bitIdx_ff <= '0;
         word_ff   <= '0;
         dlpIdx_ff <= '0;
         ioOut_ff  <= '0;
         ioOe_ff   <= '0;
      end else begin
         ioOut_ff <= nxt_ioOut;
         ioOe_ff  <= nxt_ioOe;
         if (csRise || csFall) begin
            bitIdx_ff <= '0;
            dlpIdx_ff <= '0;
         end else begin
            if (outGo) begin
               bitIdx_ff <= (bitIdx_ff == lastIdx) ? '0 : bitIdx_ff + 3'h1;
            end
            if (outGo && wordNew) begin
               word_ff <= fifoOut;
            end
            if (dlpGo) begin
               dlpIdx_ff <= dlpIdx_ff + 3'h1;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // outputs, all registered
   // ---------------------------------------------------------------
   assign ioOut     = ioOut_ff;
   assign ioOe      = ioOe_ff;
   assign bankValue = bank_ff;
   assign contMode  = contMode_ff;
   assign arrReq    = arrReq_ff;
   assign arrAddr   = arrAddr_ff;

endmodule
`default_nettype wire

// ==== dv/sfar_top_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
module sfar_top_checker (
   input wire logic        clk_sys,
   input wire logic        resetn,
   input wire logic        csN,
   input wire logic [7:0]  ioOe,
   input wire logic        bankLoad,
   input wire logic [7:0]  bankData,
   input wire logic [7:0]  bankValue,
   input wire logic        contMode,
   input wire logic        arrReq,
   input wire logic [31:0] arrAddr,
   input wire logic        arrValid
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   // cs seen high longer than the sync chain
   sequence sDesel; csN [*4]; endsequence
   chk_reset_clear: assert property ($rose(resetn) |-> !contMode && bankValue == 8'h00)
      else $error("reset values wrong");
   chk_bank_load: assert property (bankLoad |=> bankValue == $past(bankData))
      else $error("bank not loaded");
   chk_desel_quiet: assert property (sDesel |-> ##[0:3] ioOe == 8'h00)
      else $error("drive after deselect");
   chk_drive_selected: assert property ($rose(|ioOe) |-> !$past(csN, 4))
      else $error("drive without select");
   chk_oe_lanes: assert property (ioOe inside {8'h00, 8'h22, 8'hff})
      else $error("odd enable set");
   chk_serial_stays: assert property (ioOe == 8'h22 |=> ioOe != 8'hff)
      else $error("lanes switched");
   chk_one_request: assert property (arrReq |=> !arrReq && $stable(arrAddr))
      else $error("request overlap");
   chk_addr_step: assert property (arrValid |=> arrAddr ==
      ($past(arrAddr) == 32'h01ff_ffff ? 32'h0 : $past(arrAddr) + 32'h1))
      else $error("address not stepped");
endmodule
bind sfar_top sfar_top_checker u_chk (.clk_sys(clk_sys), .resetn(resetn), .csN(csN),
   .ioOe(ioOe), .bankLoad(bankLoad), .bankData(bankData), .bankValue(bankValue),
   .contMode(contMode), .arrReq(arrReq), .arrAddr(arrAddr), .arrValid(arrValid));
`default_nettype wire

// ==== dv/sfar_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module sfar_host_model (
   input  wire logic       clk_sys,
   input  wire logic [7:0] ioOut,
   input  wire logic [7:0] ioOe,
   output var  logic       sck = 1'b0,
   output var  logic       csN = 1'b1,
   output var  logic [7:0] ioIn = 8'h5a
);
   logic [15:0] word [2];
   int          oeCycles = 0;
   // counts cycles with any pin driven by the device
   always @(posedge clk_sys) oeCycles <= oeCycles + int'(|ioOe);
   // 320 ns period, under every limit
   task automatic rise;
      repeat (4) @(posedge clk_sys);
      sck <= 1'b1;
      repeat (4) @(posedge clk_sys);
   endtask
   // short aBits makes an aborted frame
   // st 4 sends address and mode as quad nibbles; nOp 0 skips the opcode
   task automatic frame(input logic [7:0] op, input logic [31:0] a, input int aBits,
                        input int dummy, input int nW, input bit quad,
                        input int st = 1, input int nOp = 8);
      csN <= 1'b0;
      for (int i = nOp - 1 + aBits; i >= 0; i--) begin
         if (i >= aBits) ioIn[0] <= op[i - aBits];
         else if (st == 1) ioIn[0] <= a[i];
         else if (i % 4 == 3) ioIn[3:0] <= a[i -: 4];
         else continue;
         rise();
         sck <= 1'b0;
      end
      for (int i = 0; i < dummy; i++) begin
         ioIn <= ~ioIn;
         rise();
         sck <= 1'b0;
      end
      // sample just before each fall, die0 in the low byte
      for (int w = 0; w < nW; w++) begin
         for (int k = 0; k < (quad ? 2 : 8); k++) begin
            ioIn <= ~ioIn;
            rise();
            word[w] = quad ? {word[w][11:8], ioOut[7:4], word[w][3:0], ioOut[3:0]}
                           : {word[w][14:8], ioOut[5], word[w][6:0], ioOut[1]};
            sck <= 1'b0;
         end
      end
      rise();
      sck <= 1'b0;
      csN <= 1'b1;
      rise();
      sck <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ==== dv/sfar_top_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module sfar_top_tb_top;
   logic        clk_sys = 1'b0;
   logic        resetn = 1'b0;
   logic [1:0]  latencyCode = 2'h0;
   logic        bankLoad = 1'b0;
   logic [7:0]  bankData = 8'h00;
   logic        arrValid = 1'b0;
   logic [15:0] arrData = 16'h0000;
   wire logic   sck;
   wire logic   csN;
   wire logic [7:0] ioIn;
   logic [7:0]  ioOut, ioOe, bankValue;
   logic        contMode, arrReq;
   logic [31:0] arrAddr;
   int          fail_count = 0;
   int          checked = 0;
   sfar_host_model host (.clk_sys(clk_sys), .ioOut(ioOut), .ioOe(ioOe), .sck(sck),
      .csN(csN), .ioIn(ioIn));
   // no double rate frames are sent, so the pattern stays off
   sfar_top dut (.clk_sys(clk_sys), .resetn(resetn), .sck(sck), .csN(csN), .ioIn(ioIn),
      .ioOut(ioOut), .ioOe(ioOe), .latencyCode(latencyCode), .dlpEnable(1'b0),
      .dlpPattern(8'h00), .bankLoad(bankLoad), .bankData(bankData), .bankValue(bankValue),
      .contMode(contMode), .arrReq(arrReq), .arrAddr(arrAddr), .arrValid(arrValid),
      .arrData(arrData));
   always #20 clk_sys = ~clk_sys;
   function automatic logic [15:0] mem(input logic [31:0] a);
      return {a[7:0] ^ a[31:24] ^ 8'h3c, a[7:0] ^ a[23:16]};
   endfunction
   // array answers one cycle after a request, reaching the fifo in the very cycle of the first zero-dummy data fall
   always @(posedge clk_sys) begin
      arrValid <= arrReq === 1'b1;
      arrData  <= mem(arrAddr);
   end
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic setup(input logic [1:0] lc, input logic [7:0] bank);
      latencyCode <= lc;
      bankLoad    <= 1'b1;
      bankData    <= bank;
      @(posedge clk_sys);
      bankLoad    <= 1'b0;
      @(posedge clk_sys);
      check({8'h00, bankValue}, {8'h00, bank});
   endtask
   task automatic rd(input logic [7:0] op, input logic [31:0] a, input int ab,
                     input int dm, input bit q, input logic [31:0] ea,
                     input int st = 1, input int nOp = 8);
      host.frame(op, a, ab, dm, 2, q, st, nOp);
      check(host.word[0], mem(ea));
      check(host.word[1], mem(ea == sfar_pkg::ADDR_LAST ? 32'h0 : ea + 32'h1));
   endtask
   task automatic test_plain;
      setup(2'h0, 8'h01);
      rd(sfar_pkg::OP_READ, 32'h1234, 24, 0, 0, 32'h0100_1234);
      rd(sfar_pkg::OP_READ_W, 32'h4321, 32, 0, 0, 32'h4321);
      setup(2'h0, 8'h80);
      rd(sfar_pkg::OP_READ, 32'h0155_0003, 32, 0, 0, 32'h0155_0003);
      $display("plain read done");
   endtask
   task automatic test_fast;
      setup(2'h0, 8'h00);
      rd(sfar_pkg::OP_FAST, 32'ha5, 24, 8, 0, 32'ha5);
      setup(sfar_pkg::LC_NO_DUMMY, 8'h00);
      rd(sfar_pkg::OP_FAST_W, 32'h0123_4567, 32, 0, 0, 32'h0123_4567);
      $display("fast read done");
   endtask
   task automatic test_quad;
      setup(2'h3, 8'h00);
      rd(sfar_pkg::OP_QOR, 32'h0777, 24, 1, 1, 32'h0777);
      setup(2'h1, 8'h00);
      rd(sfar_pkg::OP_QOR_W, 32'h01aa_0000, 32, 4, 1, 32'h01aa_0000);
      setup(2'h3, 8'h00);
      rd(sfar_pkg::OP_QIO, {24'h000200, 8'ha5}, 32, 1, 1, 32'h0200, 4);
      check({15'h0000, contMode}, 16'h0001);
      rd(8'h00, {24'h000300, 8'h00}, 32, 1, 1, 32'h0300, 4, 0);
      check({15'h0000, contMode}, 16'h0000);
      $display("quad read done");
   endtask
   task automatic test_edge;
      int oe0;
      setup(2'h0, 8'h00);
      rd(sfar_pkg::OP_READ_W, sfar_pkg::ADDR_LAST, 32, 0, 0, sfar_pkg::ADDR_LAST);
      oe0 = host.oeCycles;
      host.frame(sfar_pkg::OP_READ, 32'hffff, 12, 0, 0, 0);
      host.frame(8'h9f, 32'h0, 24, 0, 1, 0);
      check(16'(host.oeCycles - oe0), 16'h0);
      rd(sfar_pkg::OP_READ, 32'h10, 24, 0, 0, 32'h10);
      $display("wrap and abort done");
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clk_sys);
      resetn <= 1'b1;
      repeat (4) @(posedge clk_sys);
      check({7'h00, contMode, bankValue}, 16'h0000);
      test_plain();
      test_fast();
      test_quad();
      test_edge();
      wrap_up();
   end
   // hang guard
   initial begin
      repeat (40000) @(posedge clk_sys);
      fail_count++;
      $display("mismatch at %0t: run timed out", $time);
      wrap_up();
   end
endmodule
`default_nettype wire
